// File: host_link.sv
// Host side of the three-wire programming link
`timescale 1ns/1ps
module host_link (
  input wire logic clk,
  output logic serial_clk,
  output logic serial_data,
  output logic latch_strobe
);
  // Link idles with clock low
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    latch_strobe = 1'b0;
  end
  // Shift one word MSB first, then raise the strobe
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      @(negedge clk);
      serial_clk = 1'b0;
      serial_data = w[i];
      @(negedge clk);
      serial_clk = 1'b1;
    end
    @(negedge clk);
    serial_clk = 1'b0;
    serial_data = ~w[0];
    @(negedge clk);
    latch_strobe = 1'b1;
    repeat (3) @(negedge clk);
    latch_strobe = 1'b0;
  endtask
endmodule // host_link

// File: serial_shifter.v
// MSB-first serial input shift register
`timescale 1ns/1ps
module serial_shifter #(
  parameter WIDTH = 32
) (
  input wire clk,
  input wire sys_rst,
  input wire shift_en,
  input wire data_in,
  output reg [WIDTH-1:0] word
);
  // Shift one bit in per enabled edge
  always @(posedge clk) begin
    if (sys_rst) begin
      word <= {WIDTH{1'b0}};
    end else if (shift_en) begin
      word <= {word[WIDTH-2:0], data_in};
    end
  end
endmodule // serial_shifter

// File: synth_prog_consts.vh
// Field positions, select codes and observe codes of the serial programming latches
`ifndef SYNTH_PROG_CONSTS_VH
`define SYNTH_PROG_CONSTS_VH
`define WORD_WIDTH 32
`define SEL_MSB 2
`define SEL_LSB 0
`define SEL_DIVIDER 3'h0
`define SEL_PHASE 3'h1
`define SEL_DENOM_REF 3'h2
`define SEL_FUNCTION 3'h3
`define SEL_CLKDIV 3'h4
`define OBS_MSB 30
`define OBS_LSB 27
`define INT_MSB 26
`define INT_LSB 15
`define FRAC_MSB 14
`define FRAC_LSB 3
`define PHASE_MSB 14
`define PHASE_LSB 3
`define NOISE_MSB 30
`define NOISE_LSB 29
`define SLIP_BIT 28
`define CUR_MSB 27
`define CUR_LSB 24
`define PRESC_BIT 22
`define HALF_BIT 21
`define DBL_BIT 20
`define RCNT_MSB 19
`define RCNT_LSB 15
`define DEN_MSB 14
`define DEN_LSB 3
`define RESEED_BIT 14
`define LOCKW_BIT 7
`define POL_BIT 6
`define PD_BIT 5
`define TRI_BIT 4
`define CRST_BIT 3
`define CDM_MSB 20
`define CDM_LSB 19
`define CDV_MSB 18
`define CDV_LSB 7
`define OBS_TRISTATE 4'h0
`define OBS_DVDD 4'h1
`define OBS_DGND 4'h2
`define OBS_RDIV 4'h3
`define OBS_NDIV 4'h4
`define OBS_LOCK 4'h6
`endif

// File: synth_prog_monitor.sv
// Port checker for the serial programming latches
`timescale 1ns/1ps
module synth_prog_monitor (
  input logic clk,
  input logic sys_rst,
  input logic latch_strobe,
  input logic divider_written,
  input logic [11:0] int_value,
  input logic [11:0] frac_value,
  input logic [11:0] denominator_value,
  input logic [11:0] phase_value,
  input logic [4:0] ref_count,
  input logic [3:0] pump_current_setting,
  input logic [1:0] noise_spur_select,
  input logic power_down,
  input logic pump_tristate,
  input logic [11:0] clkdiv_value
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_pulse_one_cycle: assert property (divider_written |=> !divider_written)
    else $error("write pulse too long");
  a_pulse_from_strobe: assert property ($rose(divider_written) |-> $past(latch_strobe))
    else $error("write pulse without strobe");
  a_den_pending: assert property ($changed(denominator_value) |-> divider_written)
    else $error("modulus moved early");
  a_ref_pending: assert property
    ($changed({phase_value, ref_count, pump_current_setting}) |-> divider_written)
    else $error("pending setting moved early");
  a_int_on_write: assert property ($changed({int_value, frac_value}) |-> divider_written)
    else $error("divide value moved without write");
  a_noise_on_strobe: assert property ($changed(noise_spur_select) |-> $past(latch_strobe))
    else $error("noise mode moved without strobe");
  a_func_on_strobe: assert property
    ($changed({power_down, pump_tristate}) |-> $past(latch_strobe))
    else $error("function bit moved without strobe");
  a_clkdiv_on_strobe: assert property ($changed(clkdiv_value) |-> $past(latch_strobe))
    else $error("clock divider moved without strobe");
  a_one_latch_only: assert property (divider_written |-> $stable(clkdiv_value))
    else $error("two latches loaded");
endmodule // synth_prog_monitor

bind synth_serial_program_latches synth_prog_monitor synth_prog_monitor_inst (.clk, .sys_rst,
  .latch_strobe, .divider_written, .int_value, .frac_value, .denominator_value, .phase_value,
  .ref_count, .pump_current_setting, .noise_spur_select, .power_down, .pump_tristate,
  .clkdiv_value);

// File: synth_serial_program_latches.v
// Serial programming latches with pending and active stages
`timescale 1ns/1ps
`include "synth_prog_consts.vh"
module synth_serial_program_latches #(
  parameter WIDTH = 32
) (
  input wire clk,
  input wire sys_rst,
  input wire serial_clk,
  input wire serial_data,
  input wire latch_strobe,
  input wire chip_enable,
  input wire ref_div_pulse,
  input wire fb_div_pulse,
  input wire lock_detect,
  output reg observe_pin,
  output reg [11:0] int_value,
  output reg [11:0] frac_value,
  output reg [11:0] denominator_value,
  output reg [11:0] phase_value,
  output reg [4:0] ref_count,
  output reg ref_doubler,
  output reg ref_halving,
  output reg [3:0] pump_current_setting,
  output reg [1:0] noise_spur_select,
  output reg slip_reduce_enable,
  output reg prescaler_sel,
  output reg modulator_reseed_control,
  output reg lock_window_select,
  output reg detector_polarity,
  output reg power_down,
  output reg pump_tristate,
  output reg counter_reset,
  output reg [1:0] clkdiv_mode,
  output reg [11:0] clkdiv_value,
  output reg divider_written
);
  reg serial_clk_q;
  reg strobe_q;
  reg [3:0] observe_select;
  reg [11:0] pend_phase;
  reg [11:0] pend_denom;
  reg [4:0] pend_ref_count;
  reg pend_doubler;
  reg pend_halving;
  reg [3:0] pend_current;
  wire [WIDTH-1:0] shift_word;
  wire shift_edge;
  wire load_edge;
  wire [2:0] latch_select_code;
  reg next_observe;

  // Decode of a select code against a target latch
  // Shared by every latch, so all of them compare the same three bits
  function sel_hit;
    input [2:0] code;
    input [2:0] target;
    begin
      sel_hit = (code == target);
    end
  endfunction

  // Edge detection of serial clock and strobe
  // Both pins idle low, so samples clear low and no false edge follows reset
  // Each level must stand a full clock period for its edge to be seen
  always @(posedge clk) begin
    if (sys_rst) begin
      serial_clk_q <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      serial_clk_q <= serial_clk;
      strobe_q <= latch_strobe;
    end
  end
  assign shift_edge = serial_clk & ~serial_clk_q;
  assign load_edge = latch_strobe & ~strobe_q;
  assign latch_select_code = shift_word[`SEL_MSB:`SEL_LSB];

  // Input shift register
  // Extra bits fall out at the top; only the last word width of bits counts
  // The select code is the last three bits shifted in
  serial_shifter #(
    .WIDTH(WIDTH)
  ) u_shifter (
    .clk(clk),
    .sys_rst(sys_rst),
    .shift_en(shift_edge),
    .data_in(serial_data),
    .word(shift_word)
  );

  // Pending stage and immediate latches
  // Codes outside the five latches match no test and change nothing
  // A strobe rising with a serial clock edge loads the word before that bit
  always @(posedge clk) begin
    if (sys_rst) begin
      pend_phase <= 12'h000;
      pend_denom <= 12'h000;
      pend_ref_count <= 5'h00;
      pend_doubler <= 1'b0;
      pend_halving <= 1'b0;
      pend_current <= 4'h0;
      noise_spur_select <= 2'h0;
      slip_reduce_enable <= 1'b0;
      prescaler_sel <= 1'b0;
      modulator_reseed_control <= 1'b0;
      lock_window_select <= 1'b0;
      detector_polarity <= 1'b0;
      power_down <= 1'b0;
      pump_tristate <= 1'b0;
      counter_reset <= 1'b0;
      clkdiv_mode <= 2'h0;
      clkdiv_value <= 12'h000;
    end else if (load_edge) begin
      if (sel_hit(latch_select_code, `SEL_PHASE)) begin
        pend_phase <= shift_word[`PHASE_MSB:`PHASE_LSB];
      end
      if (sel_hit(latch_select_code, `SEL_DENOM_REF)) begin
        noise_spur_select <= shift_word[`NOISE_MSB:`NOISE_LSB];
        slip_reduce_enable <= shift_word[`SLIP_BIT];
        pend_current <= shift_word[`CUR_MSB:`CUR_LSB];
        prescaler_sel <= shift_word[`PRESC_BIT];
        pend_halving <= shift_word[`HALF_BIT];
        pend_doubler <= shift_word[`DBL_BIT];
        pend_ref_count <= shift_word[`RCNT_MSB:`RCNT_LSB];
        pend_denom <= shift_word[`DEN_MSB:`DEN_LSB];
      end
      if (sel_hit(latch_select_code, `SEL_FUNCTION)) begin
        modulator_reseed_control <= shift_word[`RESEED_BIT];
        lock_window_select <= shift_word[`LOCKW_BIT];
        detector_polarity <= shift_word[`POL_BIT];
        power_down <= shift_word[`PD_BIT];
        pump_tristate <= shift_word[`TRI_BIT];
        counter_reset <= shift_word[`CRST_BIT];
      end
      if (sel_hit(latch_select_code, `SEL_CLKDIV)) begin
        clkdiv_mode <= shift_word[`CDM_MSB:`CDM_LSB];
        clkdiv_value <= shift_word[`CDV_MSB:`CDV_LSB];
      end
    end
  end

  // Divider latch write promotes pending settings to active
  // The whole pending set moves on one edge, so the loop never sees a mix
  // of old and new modulus, reference and current settings
  always @(posedge clk) begin
    if (sys_rst) begin
      int_value <= 12'h000;
      frac_value <= 12'h000;
      observe_select <= 4'h0;
      phase_value <= 12'h000;
      denominator_value <= 12'h000;
      ref_count <= 5'h00;
      ref_doubler <= 1'b0;
      ref_halving <= 1'b0;
      pump_current_setting <= 4'h0;
      divider_written <= 1'b0;
    end else begin
      divider_written <= 1'b0;
      if (load_edge && sel_hit(latch_select_code, `SEL_DIVIDER)) begin
        observe_select <= shift_word[`OBS_MSB:`OBS_LSB];
        int_value <= shift_word[`INT_MSB:`INT_LSB];
        frac_value <= shift_word[`FRAC_MSB:`FRAC_LSB];
        phase_value <= pend_phase;
        denominator_value <= pend_denom;
        ref_count <= pend_ref_count;
        ref_doubler <= pend_doubler;
        ref_halving <= pend_halving;
        pump_current_setting <= pend_current;
        divider_written <= 1'b1;
      end
    end
  end

  // Observation multiplexer
  // Lock shows only while enabled and not powered down
  // The pump three-state itself sits in the analog section
  always @* begin
    case (observe_select)
      `OBS_TRISTATE: next_observe = 1'b0;
      `OBS_DVDD: next_observe = 1'b1;
      `OBS_DGND: next_observe = 1'b0;
      `OBS_RDIV: next_observe = ref_div_pulse;
      `OBS_NDIV: next_observe = fb_div_pulse;
      `OBS_LOCK: next_observe = lock_detect & chip_enable & ~power_down;
      default: next_observe = 1'b0;
    endcase
  end

  // Registered observation pin
  // One extra cycle keeps decode glitches off the pin
  always @(posedge clk) begin
    if (sys_rst) begin
      observe_pin <= 1'b0;
    end else begin
      observe_pin <= next_observe;
    end
  end
endmodule // synth_serial_program_latches

// File: synth_serial_program_latches_bench.sv
// Self-checking bench for the serial programming latches
`timescale 1ns/1ps
module synth_serial_program_latches_bench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic chip_enable = 1'b1;
  logic ref_div_pulse = 1'b1;
  logic fb_div_pulse = 1'b0;
  logic lock_detect = 1'b1;
  logic wr_seen = 1'b0;
  logic [3:0] obs_sel [7] = '{4'h0, 4'hF, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6};
  logic obs_exp [7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  wire serial_clk, serial_data, latch_strobe, observe_pin, ref_doubler, ref_halving;
  wire slip_reduce_enable, prescaler_sel, modulator_reseed_control, lock_window_select;
  wire detector_polarity, power_down, pump_tristate, counter_reset, divider_written;
  wire [11:0] int_value, frac_value, denominator_value, phase_value, clkdiv_value;
  wire [4:0] ref_count;
  wire [3:0] pump_current_setting;
  wire [1:0] noise_spur_select, clkdiv_mode;
  int n_fail = 0;
  int n_compared = 0;
  host_link host_link_inst (.clk, .serial_clk, .serial_data, .latch_strobe);
  synth_serial_program_latches synth_serial_program_latches_inst (.clk, .sys_rst,
    .serial_clk, .serial_data, .latch_strobe, .chip_enable, .ref_div_pulse, .fb_div_pulse,
    .lock_detect, .observe_pin, .int_value, .frac_value, .denominator_value, .phase_value,
    .ref_count, .ref_doubler, .ref_halving, .pump_current_setting, .noise_spur_select,
    .slip_reduce_enable, .prescaler_sel, .modulator_reseed_control, .lock_window_select,
    .detector_polarity, .power_down, .pump_tristate, .counter_reset, .clkdiv_mode,
    .clkdiv_value, .divider_written);
  // Clock
  initial forever #25 clk = ~clk;
  // Remember any divider write pulse
  always @(posedge clk) if (divider_written === 1'b1) wr_seen <= 1'b1;
  // Compare and count
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One word, then let the latch settle
  task automatic wr(input logic [31:0] w);
    host_link_inst.send(w);
    repeat (3) @(negedge clk);
  endtask
  // Verdict and end of run
  task automatic wrap_up;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  // Test sequence
  initial begin
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    wr({17'h0, 12'h123, 3'h1});
    wr({1'b0, 2'h2, 1'b1, 4'hA, 1'b0, 3'h7, 5'h15, 12'h7D0, 3'h2});
    chk("noise", {29'h0, 2'h2, 1'b1}, {noise_spur_select, slip_reduce_enable});
    chk("presc", 1'b1, prescaler_sel);
    chk("pend a", 0, {phase_value, denominator_value});
    chk("pend b", 0, {ref_count, pump_current_setting, ref_doubler, ref_halving});
    $display("test pending stage done");
    wr({1'b0, 4'h1, 12'h0C8, 12'h3E7, 3'h0});
    chk("int", 12'h0C8, int_value);
    chk("frac", 12'h3E7, frac_value);
    chk("phase", 12'h123, phase_value);
    chk("denom", 12'h7D0, denominator_value);
    chk("refs", {5'h15, 4'hA, 2'h3}, {ref_count, pump_current_setting, ref_doubler, ref_halving});
    chk("written", 1'b1, wr_seen);
    $display("test divider write done");
    // First pass inverts the observed points so each selection is told apart
    for (int p = 1; p >= 0; p--) begin
      ref_div_pulse = (p == 0);
      fb_div_pulse = (p == 1);
      lock_detect = (p == 0);
      for (int k = 0; k < 7; k++) begin
        wr({1'b0, obs_sel[k], 12'h0C8, 12'h3E7, 3'h0});
        chk("observe", obs_exp[k] ^ (p == 1 && k > 3), observe_pin);
      end
    end
    chip_enable = 1'b0;
    repeat (3) @(negedge clk);
    chk("observe ce", 1'b0, observe_pin);
    chip_enable = 1'b1;
    repeat (3) @(negedge clk);
    chk("observe ce back", 1'b1, observe_pin);
    $display("test observe done");
    wr({17'h0, 1'b1, 6'h0, 5'h0A, 3'h3});
    chk("func a", 6'h2A, {modulator_reseed_control, lock_window_select, detector_polarity,
      power_down, pump_tristate, counter_reset});
    wr({17'h0, 1'b0, 6'h0, 5'h15, 3'h3});
    chk("func b", 6'h15, {modulator_reseed_control, lock_window_select, detector_polarity,
      power_down, pump_tristate, counter_reset});
    chk("observe pd", 1'b0, observe_pin);
    wr({11'h0, 2'h3, 12'hABC, 4'h0, 3'h4});
    chk("clkdiv", {2'h3, 12'hABC}, {clkdiv_mode, clkdiv_value});
    wr({11'h0, 2'h1, 12'h555, 4'h0, 3'h5});
    chk("bad code", {2'h3, 12'hABC}, {clkdiv_mode, clkdiv_value});
    chk("int kept", 12'h0C8, int_value);
    $display("test other latches done");
    wrap_up();
  end
endmodule // synth_serial_program_latches_bench
